// [core/dwd_defines.svh]
// constants for the disk write-dma command block: offsets, field positions,
// command codes and reset values.
// assumes inclusion by bare name from the package and the top module.
//
// Summary of operation
// - terminate write dma on unrecoverable error
// - load address registers with first failing sector
// - icrc bit 7 on ultra dma crc error
// - wp bit 6 when removable media protected
// - mc bit 5 on media change, clear state
// - idnf bit 4 for three address cases
// - mcr bit 3 held until media access
// - abrt bit 2: unsupported, udma error, fault, range
// - nm bit 1 when no media present
// - error status: bsy0 drdy1 df drq0 err
// - decode cch as queued write dma
// - queued length from features, zero means 256
// - tag in count bits 7:3, any 0..31
// - start address from four registers, bit6 lba
// - queued transfer now or after service
// - interrupt reason rel io cd all zero
// - setup status: bsy0 drdy1 df0 drq1 chk0
// - serv bit 4 if another command ready
// - return own tag in count bits 7:3
// - decode cah as plain write dma
// - plain length from count, zero means 256
`ifndef DWD_DEFINES_SVH
`define DWD_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets (read / write share some addresses)
// ----------------------------------------------------------------
`define DWD_OFS_ERR_FEAT 8'h04
`define DWD_OFS_COUNT 8'h08
`define DWD_OFS_SECTOR 8'h0c
`define DWD_OFS_CYL_LO 8'h10
`define DWD_OFS_CYL_HI 8'h14
`define DWD_OFS_DRV_HEAD 8'h18
`define DWD_OFS_STAT_CMD 8'h1c
`define DWD_OFS_CTRL 8'h20
`define DWD_OFS_SERVICE 8'h24

// ----------------------------------------------------------------
// command codes and lengths
// ----------------------------------------------------------------
`define DWD_CMD_WRITE_DMA 8'hca
`define DWD_CMD_WRITE_DMA_Q 8'hcc
`define DWD_SECT_MAX 9'h100

// ----------------------------------------------------------------
// error register bits
// ----------------------------------------------------------------
`define DWD_ERR_ICRC 7
`define DWD_ERR_WP 6
`define DWD_ERR_MC 5
`define DWD_ERR_IDNF 4
`define DWD_ERR_MCR 3
`define DWD_ERR_ABRT 2
`define DWD_ERR_NM 1

// ----------------------------------------------------------------
// other fields
// ----------------------------------------------------------------
`define DWD_DH_LBA 6
`define DWD_REASON_DATA_OUT 3'h0
`define DWD_REASON_DONE 3'h3
`define DWD_CTRL_REMOVABLE 0
`define DWD_CTRL_QUEUE_EN 1
`define DWD_CTRL_DEFER 2
`define DWD_CTRL_OOR_IDNF 3
`define DWD_CTRL_RST 4'h0

`endif

// [core/dwd_pkg.sv]
// types for the disk write-dma command block.
// assumes dwd_defines.svh is on the include path.
`include "dwd_defines.svh"

package dwd_pkg;

  typedef enum logic [2:0] {
    DWD_IDLE = 3'b001,
    DWD_WAIT = 3'b010,
    DWD_XFER = 3'b100
  } dwd_state_t;

  typedef struct packed {
    logic present;
    logic wp;
    logic chg_evt;
    logic mcr_evt;
    logic chs_bad;
  } dwd_media_t;

  typedef struct packed {
    logic done;
    logic err_evt;
    logic crc;
    logic not_found;
    logic out_range;
    logic fault;
    logic udma;
    logic other_ready;
    logic [27:0] fail_lba;
  } dwd_eng_t;

  typedef struct packed {
    logic req;
    logic queued;
    logic is_lba;
    logic [4:0] tag;
    logic [8:0] sectors;
    logic [27:0] lba;
  } dwd_xfer_t;

  typedef struct packed {
    logic [7:0] feat;
    logic [7:0] cnt;
    logic [7:0] sec;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] dh;
  } dwd_task_t;

  typedef struct packed {
    logic bsy;
    logic drdy;
    logic df;
    logic serv;
    logic drq;
    logic errb;
  } dwd_stat_t;

  typedef struct packed {
    dwd_state_t state;
    dwd_task_t task_f;
    logic [7:0] err;
    dwd_stat_t stat;
    logic queued;
    logic [4:0] tag;
    logic mc_pend;
    logic mcr_pend;
    logic [3:0] ctrl;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    dwd_xfer_t xfer;
  } dwd_st_t;

endpackage

// [core/dwd_top.sv]
// task-file command interpreter for plain and queued write dma, with an
// ahb-lite slave for the task-file registers.
// assumes the dma engine and media sensors run on CLK_SYS (no sync needed)
// and that a single command is outstanding at a time.
`include "dwd_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module dwd_top (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire dwd_pkg::dwd_media_t MEDIA,
  input wire dwd_pkg::dwd_eng_t ENG,
  output dwd_pkg::dwd_xfer_t XFER
);

  dwd_pkg::dwd_st_t st_r;
  dwd_pkg::dwd_st_t st_nxt;

  logic [7:0] wd;
  logic cmd_go;
  logic svc_go;
  logic is_plain;
  logic is_q;
  logic q_on;
  logic [4:0] new_tag;
  logic [8:0] new_len;
  logic [7:0] media_e;
  logic setup;
  logic fin;
  logic [7:0] fin_e;
  logic fin_df;
  logic clr_mc;
  logic clr_mcr;
  logic [7:0] rd_byte;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.hreadyout = 1'b1;
    st_nxt.hresp = 1'b0;
    wd = HWDATA[7:0];
    cmd_go = 1'b0;
    svc_go = 1'b0;
    setup = 1'b0;
    fin = 1'b0;
    fin_e = 8'h00;
    fin_df = 1'b0;
    clr_mc = 1'b0;
    clr_mcr = 1'b0;
    media_e = 8'h00;
    rd_byte = 8'h00;

    // bus data phase of a write: task file only changes while idle
    if (st_r.dph_wr) begin
      case (st_r.dph_addr)
        `DWD_OFS_ERR_FEAT: begin
          if (st_r.state == dwd_pkg::DWD_IDLE) begin
            st_nxt.task_f.feat = wd;
          end
        end
        `DWD_OFS_COUNT: begin
          if (st_r.state == dwd_pkg::DWD_IDLE) begin
            st_nxt.task_f.cnt = wd;
          end
        end
        `DWD_OFS_SECTOR: begin
          if (st_r.state == dwd_pkg::DWD_IDLE) begin
            st_nxt.task_f.sec = wd;
          end
        end
        `DWD_OFS_CYL_LO: begin
          if (st_r.state == dwd_pkg::DWD_IDLE) begin
            st_nxt.task_f.cyl_lo = wd;
          end
        end
        `DWD_OFS_CYL_HI: begin
          if (st_r.state == dwd_pkg::DWD_IDLE) begin
            st_nxt.task_f.cyl_hi = wd;
          end
        end
        `DWD_OFS_DRV_HEAD: begin
          if (st_r.state == dwd_pkg::DWD_IDLE) begin
            st_nxt.task_f.dh = wd;
          end
        end
        `DWD_OFS_STAT_CMD: begin
          // a command is taken only while ready and idle
          cmd_go = (st_r.state == dwd_pkg::DWD_IDLE) &&
                   st_r.stat.drdy;
        end
        `DWD_OFS_CTRL: begin
          st_nxt.ctrl = HWDATA[3:0];
        end
        `DWD_OFS_SERVICE: begin
          svc_go = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // command decode values, valid in the cycle of cmd_go
    is_plain = (wd == `DWD_CMD_WRITE_DMA);
    is_q = (wd == `DWD_CMD_WRITE_DMA_Q);
    q_on = is_q && st_r.ctrl[`DWD_CTRL_QUEUE_EN];
    // every tag value is taken; no depth check here
    new_tag = q_on ? st_r.task_f.cnt[7:3] : 5'h00;
    if (is_q) begin
      new_len = (st_r.task_f.feat == 8'h00) ? `DWD_SECT_MAX :
                {1'b0, st_r.task_f.feat};
    end else begin
      new_len = (st_r.task_f.cnt == 8'h00) ? `DWD_SECT_MAX :
                {1'b0, st_r.task_f.cnt};
    end
    if (st_r.ctrl[`DWD_CTRL_REMOVABLE]) begin
      media_e[`DWD_ERR_NM] = ~MEDIA.present;
      media_e[`DWD_ERR_WP] = MEDIA.wp;
      media_e[`DWD_ERR_MC] = st_r.mc_pend;
      media_e[`DWD_ERR_MCR] = st_r.mcr_pend;
    end
    // no valid chs translation: chs addressing cannot be resolved
    media_e[`DWD_ERR_IDNF] = MEDIA.chs_bad &&
                             !st_r.task_f.dh[`DWD_DH_LBA];

    // ----------------------------------------------------------------
    // command sequencer
    // ----------------------------------------------------------------
    case (st_r.state)
      dwd_pkg::DWD_IDLE: begin
        if (cmd_go) begin
          if (!(is_plain || is_q)) begin
            st_nxt.queued = 1'b0;
            st_nxt.tag = 5'h00;
            fin = 1'b1;
            fin_e[`DWD_ERR_ABRT] = 1'b1;
          end else begin
            st_nxt.queued = is_q;
            st_nxt.tag = new_tag;
            // a media access clears the change request, reported or not
            clr_mcr = 1'b1;
            clr_mc = st_r.ctrl[`DWD_CTRL_REMOVABLE];
            if (media_e != 8'h00) begin
              // address registers still hold the first failing sector
              fin = 1'b1;
              fin_e = media_e;
            end else begin
              st_nxt.xfer.queued = is_q;
              st_nxt.xfer.tag = new_tag;
              st_nxt.xfer.sectors = new_len;
              st_nxt.xfer.is_lba = st_r.task_f.dh[`DWD_DH_LBA];
              st_nxt.xfer.lba = {st_r.task_f.dh[3:0], st_r.task_f.cyl_hi,
                                 st_r.task_f.cyl_lo,
                                 st_r.task_f.sec};
              if (is_q && st_r.ctrl[`DWD_CTRL_DEFER]) begin
                // wait for the host's service request
                st_nxt.state = dwd_pkg::DWD_WAIT;
                st_nxt.err = 8'h00;
                st_nxt.stat.bsy = 1'b0;
                st_nxt.stat.drdy = 1'b1;
                st_nxt.stat.df = 1'b0;
                st_nxt.stat.serv = 1'b0;
                st_nxt.stat.drq = 1'b0;
                st_nxt.stat.errb = 1'b0;
              end else begin
                setup = 1'b1;
              end
            end
          end
        end
      end
      dwd_pkg::DWD_WAIT: begin
        if (svc_go) begin
          setup = 1'b1;
        end
      end
      dwd_pkg::DWD_XFER: begin
        st_nxt.stat.serv = st_r.queued && ENG.other_ready;
        if (ENG.err_evt) begin
          st_nxt.task_f.sec = ENG.fail_lba[7:0];
          st_nxt.task_f.cyl_lo = ENG.fail_lba[15:8];
          st_nxt.task_f.cyl_hi = ENG.fail_lba[23:16];
          st_nxt.task_f.dh[3:0] = ENG.fail_lba[27:24];
          fin = 1'b1;
          fin_df = ENG.fault;
          // crc bit is meaningless outside ultra dma
          fin_e[`DWD_ERR_ICRC] = ENG.crc && ENG.udma;
          fin_e[`DWD_ERR_IDNF] = ENG.not_found ||
            (ENG.out_range && st_r.ctrl[`DWD_CTRL_OOR_IDNF]);
          fin_e[`DWD_ERR_ABRT] = ENG.udma || ENG.fault ||
            (ENG.out_range && !st_r.ctrl[`DWD_CTRL_OOR_IDNF]);
        end else if (ENG.done) begin
          fin = 1'b1;
        end
      end
      default: begin
        st_nxt.state = dwd_pkg::DWD_IDLE;
        st_nxt.xfer.req = 1'b0;
      end
    endcase

    // ----------------------------------------------------------------
    // data transfer setup
    // ----------------------------------------------------------------
    if (setup) begin
      st_nxt.state = dwd_pkg::DWD_XFER;
      st_nxt.xfer.req = 1'b1;
      st_nxt.err = 8'h00;
      st_nxt.stat.bsy = 1'b0;
      st_nxt.stat.drdy = 1'b1;
      st_nxt.stat.df = 1'b0;
      st_nxt.stat.drq = 1'b1;
      st_nxt.stat.errb = 1'b0;
      st_nxt.stat.serv = st_nxt.queued && ENG.other_ready;
      if (st_nxt.queued) begin
        st_nxt.task_f.cnt = {st_nxt.tag,
                             `DWD_REASON_DATA_OUT};
      end
    end

    // ----------------------------------------------------------------
    // completion, with or without error
    // ----------------------------------------------------------------
    if (fin) begin
      st_nxt.state = dwd_pkg::DWD_IDLE;
      st_nxt.xfer.req = 1'b0;
      st_nxt.err = fin_e;
      st_nxt.stat.bsy = 1'b0;
      st_nxt.stat.drdy = 1'b1;
      st_nxt.stat.df = fin_df;
      st_nxt.stat.drq = 1'b0;
      st_nxt.stat.errb = (fin_e != 8'h00);
      st_nxt.stat.serv = st_nxt.queued && ENG.other_ready;
      if (st_nxt.queued) begin
        st_nxt.task_f.cnt = {st_nxt.tag, `DWD_REASON_DONE};
      end else begin
        st_nxt.task_f.cnt = 8'h00;
      end
    end

    // sticky media flags: a new event beats a same-cycle clear
    st_nxt.mc_pend = (st_r.mc_pend && !clr_mc) || MEDIA.chg_evt;
    st_nxt.mcr_pend = (st_r.mcr_pend && !clr_mcr) || MEDIA.mcr_evt;

    // ----------------------------------------------------------------
    // bus address phase; reads see this cycle's writes
    // ----------------------------------------------------------------
    st_nxt.dph_wr = 1'b0;
    if (HSEL && HREADY && HTRANS[1]) begin
      st_nxt.dph_wr = HWRITE;
      st_nxt.dph_addr = HADDR[7:0];
      if (!HWRITE) begin
        case (HADDR[7:0])
          `DWD_OFS_ERR_FEAT: rd_byte = st_nxt.err;
          `DWD_OFS_COUNT: rd_byte = st_nxt.task_f.cnt;
          `DWD_OFS_SECTOR: rd_byte = st_nxt.task_f.sec;
          `DWD_OFS_CYL_LO: rd_byte = st_nxt.task_f.cyl_lo;
          `DWD_OFS_CYL_HI: rd_byte = st_nxt.task_f.cyl_hi;
          `DWD_OFS_DRV_HEAD: begin
            rd_byte = {1'b0, st_nxt.task_f.dh[6], 1'b0,
                       st_nxt.task_f.dh[4:0]};
          end
          `DWD_OFS_STAT_CMD: begin
            rd_byte = {st_nxt.stat.bsy, st_nxt.stat.drdy, st_nxt.stat.df,
                       st_nxt.stat.serv, st_nxt.stat.drq, 2'b00,
                       st_nxt.stat.errb};
          end
          `DWD_OFS_CTRL: rd_byte = {1'b0, st_nxt.state, st_nxt.ctrl};
          default: rd_byte = 8'h00;
        endcase
        st_nxt.hrdata = {24'h000000, rd_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st_r <= '0;
      st_r.state <= dwd_pkg::DWD_IDLE;
      st_r.stat.drdy <= 1'b1;
      st_r.ctrl <= `DWD_CTRL_RST;
      st_r.hreadyout <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign HRDATA = st_r.hrdata;
  assign HREADYOUT = st_r.hreadyout;
  assign HRESP = st_r.hresp;
  assign XFER = st_r.xfer;

endmodule

`default_nettype wire

// [test/dwd_eng_model.sv]
// dma engine model: ends each transfer after a programmed wait.
// assumes the bench sets wait_cyc and fail before each command.
`timescale 1ns/100ps
`default_nettype none

module dwd_eng_model (
  input wire logic clk,
  input wire logic rst,
  input wire dwd_pkg::dwd_xfer_t xfer,
  input wire logic [7:0] wait_cyc,
  input wire dwd_pkg::dwd_eng_t fail,
  output dwd_pkg::dwd_eng_t eng
);
  logic [7:0] cnt_r;
  logic [35:0] junk_r;
  logic fire;
  assign fire = xfer.req && cnt_r == 8'h0;
  always_ff @(posedge clk) begin
    if (rst) junk_r <= 36'h5a3c96e1b;
    else junk_r <= {junk_r[34:0], ~junk_r[35]};
    if (rst || !xfer.req) cnt_r <= wait_cyc;
    else if (cnt_r != 8'h0) cnt_r <= cnt_r - 8'h1;
  end
  // ------
  // fields that only err_evt qualifies, except udma, carry noise otherwise
  // ------
  always_comb begin
    eng = junk_r;
    eng.done = fire && !fail.err_evt;
    eng.err_evt = 1'b0;
    eng.udma = fail.udma;
    eng.other_ready = fail.other_ready;
    if (fire && fail.err_evt) eng = fail;
  end
endmodule

`default_nettype wire

// [test/dwd_asserts.sv]
// port properties of the write-dma command block.
// assumes a bind to every dwd_top instance.
`timescale 1ns/100ps
`default_nettype none

module dwd_asserts (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire dwd_pkg::dwd_eng_t ENG,
  input wire dwd_pkg::dwd_xfer_t XFER
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  wire logic rd_tk = HSEL && HREADY && HTRANS[1] && !HWRITE;
  property p_okay;
    HREADYOUT && !HRESP;
  endproperty
  a_okay: assert property (p_okay) else $error("bus wait or error");
  property p_hi0;
    HRDATA[31:8] == 24'h0;
  endproperty
  a_hi0: assert property (p_hi0)
    else $error("upper read bits set");
  property p_hold_rd;
    !rd_tk |=> $stable(HRDATA);
  endproperty
  a_hold_rd: assert property (p_hold_rd) else $error("read data moved");
  property p_err_end;
    XFER.req && ENG.err_evt |=> !XFER.req;
  endproperty
  a_err_end: assert property (p_err_end)
    else $error("no stop on error");
  property p_done_end;
    XFER.req && ENG.done |=> !XFER.req ##1 !XFER.req;
  endproperty
  a_done_end: assert property (p_done_end) else $error("no stop on done");
  property p_len;
    XFER.req |-> XFER.sectors != 9'h0 && XFER.sectors <= 9'h100;
  endproperty
  a_len: assert property (p_len)
    else $error("length out of range");
  property p_hold;
    XFER.req && !ENG.done && !ENG.err_evt |=> XFER.req &&
      $stable({XFER.tag, XFER.sectors, XFER.lba, XFER.is_lba});
  endproperty
  a_hold: assert property (p_hold)
    else $error("transfer changed");
  property p_plain;
    $rose(XFER.req) && !XFER.queued |-> $past(HWDATA[7:0]) == 8'hca;
  endproperty
  a_plain: assert property (p_plain)
    else $error("plain start w/o code");
  c_queued: cover property ($rose(XFER.req) && XFER.queued);
  c_err: cover property (XFER.req && ENG.err_evt);
  c_done: cover property (XFER.req && ENG.done);
endmodule

bind dwd_top dwd_asserts u_asserts (.CLK_SYS, .RST, .HSEL, .HTRANS,
  .HWRITE, .HREADY, .HWDATA, .HRDATA, .HREADYOUT, .HRESP, .ENG, .XFER);

`default_nettype wire

// [test/dwd_top_tb.sv]
// self-checking bench for the write-dma command block.
// assumes dwd_pkg, the engine model and the checker are compiled first.
`include "dwd_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module dwd_top_tb;
  localparam logic [7:0] A_ST = `DWD_OFS_STAT_CMD;
  localparam logic [7:0] A_ER = `DWD_OFS_ERR_FEAT;
  localparam logic [7:0] A_CN = `DWD_OFS_COUNT;
  localparam logic [7:0] A_CT = `DWD_OFS_CTRL;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'b00;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT;
  logic HRESP;
  dwd_pkg::dwd_media_t MEDIA = '0;
  dwd_pkg::dwd_eng_t ENG;
  dwd_pkg::dwd_eng_t fail = '0;
  dwd_pkg::dwd_xfer_t XFER;
  logic [7:0] wait_cyc = 8'h28;
  logic [31:0] rv = 32'hb8d98092;
  logic [27:0] lba;
  logic [7:0] q, cnt, code, ee;
  logic [7:0] feat = 8'h00;
  dwd_pkg::dwd_eng_t fe;
  logic [4:0] tg;
  logic [8:0] ln;
  logic [3:0] cf;
  logic qd;
  int num_errors = 0;
  int compares = 0;

  always #5 CLK_SYS = ~CLK_SYS;

  dwd_top u_dut (.CLK_SYS, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE,
    .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT,
    .HRESP, .MEDIA, .ENG, .XFER);
  dwd_eng_model u_eng (.clk(CLK_SYS), .rst(RST), .xfer(XFER),
    .wait_cyc, .fail, .eng(ENG));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] err_exp(input dwd_pkg::dwd_eng_t e,
                                         input logic oi);
    return {e.crc & e.udma, 2'b00, e.not_found | (e.out_range & oi),
      1'b0, e.udma | e.fault | (e.out_range & !oi), 2'b00};
  endfunction
  task automatic chk(input logic [47:0] s, e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d,
                     output logic [7:0] o);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    @(posedge CLK_SYS);
    while (HREADYOUT !== 1'b1) @(posedge CLK_SYS);
    HTRANS <= 2'b00;
    HWDATA <= {24'h0, d};
    @(posedge CLK_SYS);
    while (HREADYOUT !== 1'b1) @(posedge CLK_SYS);
    o = HRDATA[7:0];
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] o;
    bus(1'b1, a, d, o);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] o);
    bus(1'b0, a, 8'h0, o);
  endtask
  task automatic cmd(input logic [7:0] c);
    rv = lfsr(rv);
    lba = rv[27:0];
    wr(A_ER, feat);
    wr(A_CN, cnt);
    wr(`DWD_OFS_SECTOR, lba[7:0]);
    wr(`DWD_OFS_CYL_LO, lba[15:8]);
    wr(`DWD_OFS_CYL_HI, lba[23:16]);
    wr(`DWD_OFS_DRV_HEAD, {1'b1, rv[31], 2'b00, lba[27:24]});
    rd(A_ST, q);
    chk(q[6], 1'b1);
    wr(A_ST, c);
  endtask
  task automatic wreq(input logic v);
    for (int i = 0; i < 60 && XFER.req !== v; i++) @(posedge CLK_SYS);
    chk(XFER.req, v);
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (4) @(posedge CLK_SYS);
    RST <= 1'b0;
    @(posedge CLK_SYS);
    rd(A_ST, q);
    chk(q, 8'h40);
    rd(8'h3c, q);
    chk(q, 8'h00);
    for (int n = 0; n < 4; n++) begin
      rv = lfsr(rv);
      code = rv[7:0];
      cnt = rv[15:8];
      if (code == 8'hca || code == 8'hcc) code = code ^ 8'h01;
      cmd(code);
      repeat (2) @(posedge CLK_SYS);
      rd(A_ER, q);
      chk(q, 8'h04);
      rd(A_ST, q);
      chk(q, 8'h41);
    end
    $display("test unsupported done");
    for (int n = 0; n < 8; n++) begin
      rv = lfsr(rv);
      qd = n[0];
      cf = {1'b0, n[2], n[1], 1'b0};
      cnt = n < 2 ? 8'h0 : rv[7:0];
      feat = n < 2 ? 8'h0 : rv[15:8];
      fail <= {7'h00, qd & rv[16], 28'h0000000};
      tg = (qd & cf[1]) ? cnt[7:3] : 5'h0;
      ln = (qd ? feat : cnt) == 8'h0 ? 9'h100 : {1'b0, qd ? feat : cnt};
      wr(A_CT, {4'h0, cf});
      cmd(qd ? 8'hcc : 8'hca);
      if (qd & cf[2]) begin
        rd(A_ST, q);
        chk({XFER.req, q}, 9'h040);
        wr(`DWD_OFS_SERVICE, 8'h00);
      end
      wreq(1'b1);
      chk({XFER.queued, XFER.is_lba, XFER.sectors, XFER.lba},
        {qd, rv[31], ln, lba});
      if (qd) chk(XFER.tag, tg);
      rd(A_ST, q);
      chk(q, {3'b010, fail.other_ready, 4'h8});
      rd(A_CN, q);
      if (qd) chk(q, {tg, 3'b000});
      wreq(1'b0);
      rd(A_ST, q);
      chk(q, {3'b010, fail.other_ready, 4'h0});
      rd(A_CN, q);
      chk(q, qd ? {tg, 3'b011} : 8'h0);
    end
    $display("test transfers done");
    for (int n = 0; n < 8; n++) begin
      rv = lfsr(rv);
      // done low, err_evt high, other_ready low, the rest random
      fe = {2'b01, rv[5:1], 1'b0, rv[27:0]};
      fail <= fe;
      cf = {rv[30], 3'b000};
      wait_cyc <= rv[29] ? 8'h00 : 8'h0c;
      cnt = rv[15:8];
      ee = err_exp(fe, cf[3]);
      wr(A_CT, {4'h0, cf});
      cmd(8'hca);
      wreq(1'b1);
      wreq(1'b0);
      rd(A_ER, q);
      chk(q, ee);
      rd(A_ST, q);
      chk(q, {2'b01, fail.fault, 4'h0, |ee});
      rd(`DWD_OFS_SECTOR, q);
      chk(q, fail.fail_lba[7:0]);
      rd(`DWD_OFS_CYL_HI, q);
      chk(q, fail.fail_lba[23:16]);
      rd(`DWD_OFS_DRV_HEAD, q);
      chk({q[7], q[5], q[3:0]},
        {2'b00, fail.fail_lba[27:24]});
    end
    $display("test errors done");
    fail <= '0;
    wait_cyc <= 8'h10;
    for (int m = 0; m < 5; m++) begin
      wr(A_CT, {7'h0, m != 4});
      MEDIA <= '{present: m != 0, wp: m == 1, chg_evt: m == 2,
        mcr_evt: m == 3, chs_bad: m == 4};
      @(posedge CLK_SYS);
      MEDIA.chg_evt <= 1'b0;
      MEDIA.mcr_evt <= 1'b0;
      cmd(8'hca);
      ee = m == 0 ? 8'h02 : m == 1 ? 8'h40 : m == 2 ? 8'h20 : m == 3 ? 8'h08
        : rv[31] ? 8'h00 : 8'h10;
      repeat (2) @(posedge CLK_SYS);
      chk(XFER.req, ee == 8'h0);
      if (ee == 8'h0) wreq(1'b0);
      rd(A_ER, q);
      chk(q, ee);
      rd(A_ST, q);
      chk(q, {7'h20, ee != 8'h0});
    end
    $display("test media done");
    stop_test();
  end
endmodule

`default_nettype wire
